// ===== rtl/qenc_pkg.sv
package qenc_pkg;
   // register offsets on the plain register port
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CONFIG = 8'h00;
   localparam logic [7:0] REG_POSITION = 8'h04;
   localparam logic [7:0] REG_STEP_CONST = 8'h08;
   localparam logic [7:0] REG_FLAGS = 8'h0C;
   localparam logic [7:0] REG_CAPTURED = 8'h10;
   localparam logic [7:0] REG_IRQ_MASK = 8'h14;
   localparam logic [7:0] REG_FRACTION = 8'h18;

   // encoder_config field layout, bit 0 upward
   localparam int CFG_W = 7;
   localparam int CFG_POL_A = 0;
   localparam int CFG_POL_B = 1;
   localparam int CFG_POL_N = 2;
   localparam int CFG_CLEAR_ON_N = 3;
   localparam int CFG_CLR_CONT = 4;
   localparam int CFG_CLR_ONCE = 5;
   localparam int CFG_DECIMAL = 6;

   // encoder_event_flags layout, shared by the irq mask
   localparam int FLAG_W = 2;
   localparam int FLAG_INDEX = 0;
   localparam int FLAG_CLEARED = 1;

   // reset values
   localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
   localparam logic [31:0] STEP_CONST_RESET = 32'h0001_0000;
   localparam logic [FLAG_W-1:0] FLAG_RESET = 2'h0;

   // timing: spike filter length in clocks, decimal fraction modulus
   localparam int FILT_LEN = 3;
   localparam logic [16:0] DEC_MODULUS = 17'h0_2710;

   typedef struct packed {
      logic decimal;
      logic clr_once;
      logic clr_cont;
      logic clear_on_n;
      logic pol_n;
      logic pol_b;
      logic pol_a;
   } cfg_type;

   typedef struct packed {
      logic [31:0] pos;
      logic [15:0] frac;
   } acc_type;
endpackage : qenc_pkg

// ===== rtl/abn_input_filter.sv
`timescale 1ns/100ps
module abn_input_filter #(
   parameter int FILT_LEN = qenc_pkg::FILT_LEN
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_pin,
   output logic o_level
);
   logic sync1_reg;
   logic sync2_reg;
   logic [FILT_LEN-1:0] hist_reg;
   wire all_high = &hist_reg;
   wire all_low = ~|hist_reg;

   ////////////////////////////////////////////////////////////////////////
   // two-flop synchroniser, then a history of settled samples
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         hist_reg <= '0;
      end else begin
         sync1_reg <= i_pin;
         sync2_reg <= sync1_reg;
         hist_reg <= {hist_reg[FILT_LEN-2:0], sync2_reg};
      end
   end

   // level moves only after FILT_LEN equal samples, so shorter spikes die [RL13]
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_level <= 1'b0;
      end else if (all_high) begin
         o_level <= 1'b1;
      end else if (all_low) begin
         o_level <= 1'b0;
      end
   end

   a_spike_reject: assert property (@(posedge i_clk) disable iff (i_srst) // [RL13]
      !$stable(o_level) |-> ($past(sync2_reg, 2) == o_level) && ($past(sync2_reg, 3) == o_level)
         && ($past(sync2_reg, 4) == o_level))
      else $error("filtered level moved after a short pulse");
endmodule : abn_input_filter

// ===== rtl/quad_step_decoder.sv
`timescale 1ns/100ps
module quad_step_decoder (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_a,
   input wire logic i_b,
   output logic o_step,
   output logic o_up
);
   logic a_prev_reg;
   logic b_prev_reg;
   // a single channel change is a valid quadrature step; both at once is dropped
   wire one_change = (i_a ^ a_prev_reg) ^ (i_b ^ b_prev_reg);
   // a leading b counts up, b leading a counts down
   wire dir_up = i_a ^ b_prev_reg; // [RL14]

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         a_prev_reg <= 1'b0;
         b_prev_reg <= 1'b0;
         o_step <= 1'b0;
         o_up <= 1'b0;
      end else begin
         a_prev_reg <= i_a;
         b_prev_reg <= i_b;
         o_step <= one_change; // [RL5]
         o_up <= dir_up; // [RL14]
      end
   end

   a_dir_a_leads: assert property (@(posedge i_clk) disable iff (i_srst) // [RL14]
      (!a_prev_reg && !b_prev_reg && i_a && !i_b) |=> o_step && o_up)
      else $error("a leading b did not count up");
   a_dir_b_leads: assert property (@(posedge i_clk) disable iff (i_srst) // [RL14]
      (!a_prev_reg && !b_prev_reg && !i_a && i_b) |=> o_step && !o_up)
      else $error("b leading a did not count down");
endmodule : quad_step_decoder

// ===== rtl/quadrature_encoder_counter.sv
// Operation
// RL1: continuous index mode acts on every qualified index event
// RL2: single-shot index mode acts once, then disarms itself
// RL3: index accepted only while a and b match their polarity bits
// RL4: index clears position only with clear-on-index set and a mode armed
// RL5: each a or b level change adds or subtracts the step constant
// RL6: step constant is signed 16.16 fixed point in binary mode
// RL7: decimal mode takes the low 16 bits as ten-thousandths, 0 to 9999
// RL8: negative step constant reverses the counting direction
// RL9: position counter register always readable with the current count
// RL10: status flags record index events and index clears
// RL11: accepted index event copies position into the capture register
// RL12: encoder transitions stay below two thirds of the clock rate; the filter passes only levels held three clocks, at most one third
// RL13: a, b and index filtered, pulses under three clocks rejected
// RL14: a leading b counts up, b leading a counts down
// RL15: with no index mode armed, index neither clears nor latches
`timescale 1ns/100ps
module quadrature_encoder_counter (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_enc_a,
   input wire logic i_enc_b,
   input wire logic i_enc_n,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_irq
);
   ////////////////////////////////////////////////////////////////////////
   // step arithmetic for both number formats
   function automatic qenc_pkg::acc_type step_acc(
      input qenc_pkg::acc_type cur,
      input logic [31:0] k,
      input logic up,
      input logic dec
   );
      qenc_pkg::acc_type res;
      logic [47:0] delta;
      logic [47:0] sum;
      logic [31:0] k_int;
      logic [16:0] f;
      logic carry;
      res = cur;
      delta = {{16{k[31]}}, k};
      sum = '0;
      k_int = {{16{k[31]}}, k[31:16]};
      f = '0;
      carry = 1'b0;
      if (!dec) begin
         // signed 16.16 added to a 32.16 accumulator; the sign flips direction
         sum = up ? ({cur.pos, cur.frac} + delta) : ({cur.pos, cur.frac} - delta); // [RL6] [RL8]
         res.pos = sum[47:16];
         res.frac = sum[15:0];
      end else if (up) begin
         // fraction counts ten-thousandths and carries into the integer [RL7]
         f = {1'b0, cur.frac} + {1'b0, k[15:0]};
         carry = (f >= qenc_pkg::DEC_MODULUS);
         f = carry ? (f - qenc_pkg::DEC_MODULUS) : f;
         res.frac = f[15:0];
         res.pos = cur.pos + k_int + {31'h0000_0000, carry};
      end else begin
         // borrow from the integer when the fraction would go negative [RL7]
         carry = (cur.frac < k[15:0]);
         f = {1'b0, cur.frac} - {1'b0, k[15:0]};
         f = carry ? (f + qenc_pkg::DEC_MODULUS) : f;
         res.frac = f[15:0];
         res.pos = cur.pos - k_int - {31'h0000_0000, carry};
      end
      return res;
   endfunction : step_acc

   ////////////////////////////////////////////////////////////////////////
   // input filtering and quadrature decode
   logic [2:0] pins;
   logic [2:0] filt;
   logic step;
   logic step_up;
   assign pins = {i_enc_n, i_enc_b, i_enc_a};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_filt
         abn_input_filter #(
            .FILT_LEN(qenc_pkg::FILT_LEN)
         ) u_filt (
            .i_clk(i_clk),
            .i_srst(i_srst),
            .i_pin(pins[gi]),
            .o_level(filt[gi]) // [RL13]
         );
      end
   endgenerate

   wire a_f = filt[0];
   wire b_f = filt[1];
   wire n_f = filt[2];

   quad_step_decoder u_dec (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_a(a_f),
      .i_b(b_f),
      .o_step(step),
      .o_up(step_up)
   );

   ////////////////////////////////////////////////////////////////////////
   // registers
   qenc_pkg::cfg_type cfg_reg;
   qenc_pkg::cfg_type cfg_next;
   qenc_pkg::acc_type acc_reg;
   qenc_pkg::acc_type acc_next;
   logic [31:0] step_const_reg;
   logic [31:0] captured_reg;
   logic [qenc_pkg::FLAG_W-1:0] flags_reg;
   logic [qenc_pkg::FLAG_W-1:0] flags_next;
   logic [qenc_pkg::FLAG_W-1:0] mask_reg;
   logic n_act_prev_reg;

   ////////////////////////////////////////////////////////////////////////
   // address decode
   wire wr_cfg = i_wr && (i_addr == qenc_pkg::REG_CONFIG);
   wire wr_pos = i_wr && (i_addr == qenc_pkg::REG_POSITION);
   wire wr_const = i_wr && (i_addr == qenc_pkg::REG_STEP_CONST);
   wire wr_flags = i_wr && (i_addr == qenc_pkg::REG_FLAGS);
   wire wr_mask = i_wr && (i_addr == qenc_pkg::REG_IRQ_MASK);

   ////////////////////////////////////////////////////////////////////////
   // index detection: active edge of the index, qualified by a and b levels
   wire n_act = (n_f == cfg_reg.pol_n);
   wire n_edge = n_act && !n_act_prev_reg;
   wire ab_qual = (a_f == cfg_reg.pol_a) && (b_f == cfg_reg.pol_b); // [RL3]
   wire accepted = n_edge && ab_qual; // [RL3]
   // either index mode arms clear and capture; neither leaves them idle
   wire armed = cfg_reg.clr_cont || cfg_reg.clr_once; // [RL1] [RL2] [RL15]
   wire do_latch = accepted && armed; // [RL11] [RL15]
   wire do_clear = do_latch && cfg_reg.clear_on_n; // [RL4]

   ////////////////////////////////////////////////////////////////////////
   // next values; a software write of the position beats index and step,
   // an index clear beats a step landing in the same cycle
   always_comb begin
      acc_next = acc_reg;
      if (wr_pos) begin
         acc_next.pos = i_wdata;
         acc_next.frac = 16'h0000;
      end else if (do_clear) begin
         acc_next = '0; // [RL4]
      end else if (step) begin
         acc_next = step_acc(acc_reg, step_const_reg, step_up, cfg_reg.decimal); // [RL5]
      end
   end

   // single-shot disarms after its event unless software rewrites the config
   always_comb begin
      cfg_next = cfg_reg;
      if (wr_cfg) begin
         cfg_next = qenc_pkg::cfg_type'(i_wdata[qenc_pkg::CFG_W-1:0]);
      end else if (do_latch && cfg_reg.clr_once) begin
         cfg_next.clr_once = 1'b0; // [RL2]
      end
   end

   // write one to clear; a new event in the same cycle wins
   always_comb begin
      flags_next = flags_reg;
      if (wr_flags) begin
         flags_next = flags_reg & ~i_wdata[qenc_pkg::FLAG_W-1:0];
      end
      if (accepted) begin
         flags_next[qenc_pkg::FLAG_INDEX] = 1'b1; // [RL10]
      end
      if (do_clear) begin
         flags_next[qenc_pkg::FLAG_CLEARED] = 1'b1; // [RL10]
      end
   end

   // read mux; unmapped offsets read zero
   logic [31:0] rd_mux;
   always_comb begin
      case (i_addr)
         qenc_pkg::REG_CONFIG: rd_mux = {25'h000_0000, cfg_reg};
         qenc_pkg::REG_POSITION: rd_mux = acc_reg.pos; // [RL9]
         qenc_pkg::REG_STEP_CONST: rd_mux = step_const_reg;
         qenc_pkg::REG_FLAGS: rd_mux = {30'h0000_0000, flags_reg};
         qenc_pkg::REG_CAPTURED: rd_mux = captured_reg;
         qenc_pkg::REG_IRQ_MASK: rd_mux = {30'h0000_0000, mask_reg};
         qenc_pkg::REG_FRACTION: rd_mux = {16'h0000, acc_reg.frac};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cfg_reg <= qenc_pkg::CFG_RESET;
         acc_reg <= '0;
         flags_reg <= qenc_pkg::FLAG_RESET;
         n_act_prev_reg <= 1'b1;
      end else begin
         cfg_reg <= cfg_next;
         acc_reg <= acc_next; // [RL9]
         flags_reg <= flags_next;
         n_act_prev_reg <= n_act;
      end
   end

   // software-only registers and the capture register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         step_const_reg <= qenc_pkg::STEP_CONST_RESET;
         mask_reg <= '0;
         captured_reg <= 32'h0000_0000;
      end else begin
         if (wr_const) begin
            step_const_reg <= i_wdata;
         end
         if (wr_mask) begin
            mask_reg <= i_wdata[qenc_pkg::FLAG_W-1:0];
         end
         if (do_latch) begin
            captured_reg <= acc_reg.pos; // [RL11]
         end
      end
   end

   // read data stand for one cycle only; irq is a registered level
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_rdata <= 32'h0000_0000;
         o_irq <= 1'b0;
      end else begin
         o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
         o_irq <= |(flags_next & mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   a_cont_repeat: assert property ( // [RL1]
      do_latch && cfg_reg.clr_cont && !wr_cfg |=> cfg_reg.clr_cont && armed)
      else $error("continuous index mode dropped after an event");
   a_once_disarm: assert property ( // [RL2]
      do_latch && cfg_reg.clr_once && !cfg_reg.clr_cont && !wr_cfg |=> !armed)
      else $error("single-shot index mode still armed");
   a_index_qualify: assert property ( // [RL3]
      n_edge && !ab_qual && !flags_reg[qenc_pkg::FLAG_INDEX] |=> !flags_reg[qenc_pkg::FLAG_INDEX])
      else $error("index accepted with a or b at wrong level");
   a_index_clear: assert property ( // [RL4]
      do_clear && !wr_pos |=> acc_reg == '0 && flags_reg[qenc_pkg::FLAG_CLEARED])
      else $error("index clear did not zero the position");
   a_unit_step: assert property ( // [RL6] [RL8]
      step && !cfg_reg.decimal && !do_clear && !wr_pos && step_const_reg == 32'h0001_0000
      |=> acc_reg.pos == $past(acc_reg.pos) + (($past(step_up)) ? 32'h0000_0001 : 32'hFFFF_FFFF))
      else $error("unit step moved the position wrongly");
   a_neg_step: assert property ( // [RL8]
      step && step_up && !cfg_reg.decimal && !do_clear && !wr_pos && step_const_reg == 32'hFFFF_0000
      |=> acc_reg.pos == $past(acc_reg.pos) - 32'h0000_0001)
      else $error("negative constant did not reverse counting");
   a_dec_frac: assert property ( // [RL7]
      cfg_reg.decimal && acc_reg.frac < 16'h2710 && step_const_reg[15:0] < 16'h2710 && !wr_pos
      |=> acc_reg.frac < 16'h2710)
      else $error("decimal fraction left 0 to 9999");
   a_read_pos: assert property ( // [RL9]
      i_rd && i_addr == qenc_pkg::REG_POSITION |=> o_rdata == $past(acc_reg.pos))
      else $error("position read returned a stale value");
   a_flag_set: assert property ( // [RL10]
      accepted |=> flags_reg[qenc_pkg::FLAG_INDEX] && (o_irq || !$past(mask_reg[qenc_pkg::FLAG_INDEX])))
      else $error("index event flag not set");
   a_capture_copy: assert property ( // [RL11]
      do_latch |=> captured_reg == $past(acc_reg.pos))
      else $error("capture register missed the position");
   a_idle_index: assert property ( // [RL15]
      accepted && !armed && !wr_pos && !step |=> $stable(captured_reg) && $stable(acc_reg))
      else $error("disarmed index touched the position");

   // software writes land at the strobe edge; read data never linger
   a_pos_write: assert property ( // [RL9]
      wr_pos |=> acc_reg.pos == $past(i_wdata) && acc_reg.frac == 16'h0000)
      else $error("position write did not land");
   a_cfg_write: assert property ( // [RL2]
      wr_cfg |=> cfg_reg == $past(i_wdata[qenc_pkg::CFG_W-1:0]))
      else $error("config write lost to the single-shot disarm");
   a_rdata_idle: assert property ( // [RL9]
      !i_rd |=> o_rdata == 32'h0000_0000)
      else $error("read data stood without a read strobe");

   // position moves only through a step, an index clear or a software write
   a_pos_hold: assert property ( // [RL5]
      !step && !do_clear && !wr_pos |=> $stable(acc_reg))
      else $error("position moved with no cause");
   // an index without clear-on-index and a mode must leave the position alone
   a_clear_gate: assert property ( // [RL4]
      accepted && !(cfg_reg.clear_on_n && (cfg_reg.clr_once || cfg_reg.clr_cont)) && !step && !wr_pos
      |=> $stable(acc_reg))
      else $error("index cleared the position while not allowed");
   a_bin_frac: assert property ( // [RL6]
      step && !cfg_reg.decimal && !do_clear && !wr_pos
      |=> acc_reg.frac == ($past(step_up) ? $past(acc_reg.frac) + $past(step_const_reg[15:0])
         : $past(acc_reg.frac) - $past(step_const_reg[15:0])))
      else $error("binary fraction moved wrongly");

   // decimal steps move the integer by the constant's integer part plus at most one carry
   wire [31:0] step_int = {{16{step_const_reg[31]}}, step_const_reg[31:16]};
   a_dec_int_up: assert property ( // [RL7]
      step && step_up && cfg_reg.decimal && !do_clear && !wr_pos
      |=> acc_reg.pos - $past(acc_reg.pos) - $past(step_int) <= 32'h0000_0001)
      else $error("decimal step up moved the integer wrongly");
   a_dec_int_down: assert property ( // [RL7]
      step && !step_up && cfg_reg.decimal && !do_clear && !wr_pos
      |=> $past(acc_reg.pos) - acc_reg.pos - $past(step_int) <= 32'h0000_0001)
      else $error("decimal step down moved the integer wrongly");

   // sticky flags: only a written one clears them, only their own event sets them
   a_flag_sticky: assert property ( // [RL10]
      flags_reg[qenc_pkg::FLAG_INDEX] && !(wr_flags && i_wdata[qenc_pkg::FLAG_INDEX])
      |=> flags_reg[qenc_pkg::FLAG_INDEX])
      else $error("index flag dropped without a clear");
   a_flag_w1c: assert property ( // [RL10]
      wr_flags && i_wdata[qenc_pkg::FLAG_INDEX] && !accepted |=> !flags_reg[qenc_pkg::FLAG_INDEX])
      else $error("index flag survived a write of one");
   a_clear_w1c: assert property ( // [RL10]
      wr_flags && i_wdata[qenc_pkg::FLAG_CLEARED] && !do_clear |=> !flags_reg[qenc_pkg::FLAG_CLEARED])
      else $error("cleared flag survived a write of one");
   a_index_cause: assert property ( // [RL10]
      $rose(flags_reg[qenc_pkg::FLAG_INDEX]) |-> $past(accepted))
      else $error("index flag set with no accepted index");
   a_cleared_cause: assert property ( // [RL4]
      $rose(flags_reg[qenc_pkg::FLAG_CLEARED]) |-> $past(do_clear))
      else $error("cleared flag set with no index clear");

   // capture moves only on an armed index; irq follows flags under a steady mask
   a_capture_hold: assert property ( // [RL11]
      !do_latch |=> $stable(captured_reg))
      else $error("capture register moved with no index");
   a_irq_level: assert property ( // [RL10]
      !$changed(mask_reg) |-> o_irq == |(flags_reg & mask_reg))
      else $error("irq level disagrees with flags and mask");
endmodule : quadrature_encoder_counter

// ===== verif/quad_encoder_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// behavioural abn encoder; idle with every pin low
module quad_encoder_model (
   input wire logic i_clk,
   output logic o_a,
   output logic o_b,
   output logic o_n
);
   initial begin
      o_a = 1'b0;
      o_b = 1'b0;
      o_n = 1'b0;
   end

   // one quadrature transition, a leads b when up; a level never holds under four clocks
   task automatic move(input logic up, input int gap);
      @(posedge i_clk);
      if ((o_a == o_b) == up) begin
         o_a <= ~o_a;
      end else begin
         o_b <= ~o_b;
      end
      repeat ((gap < 4) ? 4 : gap) @(posedge i_clk);
   endtask : move

   // index pulse on n, or a deliberate spike on a when on_a is set
   task automatic pulse(input logic on_a, input int len);
      @(posedge i_clk);
      if (on_a) o_a <= ~o_a;
      else o_n <= 1'b1;
      repeat (len) @(posedge i_clk);
      if (on_a) o_a <= ~o_a;
      else o_n <= 1'b0;
      repeat (8) @(posedge i_clk);
   endtask : pulse
endmodule : quad_encoder_model

// ===== verif/tb_quadrature_encoder_counter.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module tb_quadrature_encoder_counter;
   logic i_clk = 1'b0;
   logic i_srst;
   logic [7:0] i_addr;
   logic [31:0] i_wdata;
   logic i_wr, i_rd, o_irq, enc_a, enc_b, enc_n;
   logic [31:0] o_rdata, k;
   logic [47:0] acc;
   int fails = 0;
   int num_checks = 0;

   // 50 mhz system clock
   always #10 i_clk = ~i_clk;

   quad_encoder_model enc (.i_clk(i_clk), .o_a(enc_a), .o_b(enc_b), .o_n(enc_n));
   quadrature_encoder_counter uut (.i_clk(i_clk), .i_srst(i_srst), .i_enc_a(enc_a), .i_enc_b(enc_b),
      .i_enc_n(enc_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_irq(o_irq));

   ////////////////////////////////////////////////////////////////////////////////
   // expected 32.16 accumulator after one step; decimal fraction wraps at the modulus
   function automatic logic [47:0] next_acc(input logic [47:0] cur, input logic [31:0] kc, input logic up,
      input logic dec);
      logic [31:0] d;
      int f;
      int m;
      if (!dec) return up ? cur + {{16{kc[31]}}, kc} : cur - {{16{kc[31]}}, kc};
      m = int'(qenc_pkg::DEC_MODULUS);
      d = {{16{kc[31]}}, kc[31:16]};
      f = up ? int'(cur[15:0]) + int'(kc[15:0]) : int'(cur[15:0]) - int'(kc[15:0]);
      if (f >= m || f < 0) begin
         f = (f < 0) ? f + m : f - m;
         d = d + 32'h1; // carry and borrow both widen the integer move
      end
      return up ? {cur[47:16] + d, f[15:0]} : {cur[47:16] - d, f[15:0]};
   endfunction : next_acc

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out

   task automatic check_reg(input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : check_reg

   task automatic check_bit(input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: irq expected %h got %h", $time, exp, got);
      end
   endtask : check_bit

   // bus cycles: one-cycle strobes, read data only in the cycle after the strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      if (a == qenc_pkg::REG_POSITION) acc = {d, 16'h0000};
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      check_reg(exp, o_rdata);
   endtask : rd_chk

   // random walk of steps, then let the eight-edge pipeline drain
   task automatic run(input int n, input logic dec);
      logic up;
      for (int i = 0; i < n; i++) begin
         up = 1'($urandom_range(0, 1));
         enc.move(up, 4 + $urandom_range(0, 2));
         acc = next_acc(acc, k, up, dec);
      end
      repeat (10) @(posedge i_clk);
   endtask : run

   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      check_bit(exp, o_irq);
   endtask : irq_chk

   ////////////////////////////////////////////////////////////////////////////////
   // hang guard
   initial begin
      repeat (100000) @(posedge i_clk);
      fails++;
      $display("Error at %0t: run limit reached", $time);
      close_out();
   end

   // main sequence
   initial begin
      i_srst = 1'b1;
      i_addr = 8'h00;
      i_wdata = 32'h0000_0000;
      i_wr = 1'b0;
      i_rd = 1'b0;
      acc = 48'h0;
      void'($urandom(7));
      repeat (3) @(posedge i_clk);
      i_srst <= 1'b0;
      for (int i = 0; i < 8; i++) rd_chk(8'(4 * i), (i == 2) ? qenc_pkg::STEP_CONST_RESET : 32'h0);
      $display("test reset values done");
      // binary mode: negative one, one half, one, then random signed constants
      for (int r = 0; r < 6; r++) begin
         k = (r == 0) ? 32'hFFFF_0000 : (r == 1) ? 32'h0000_8000 : (r == 2) ? 32'h0001_0000 : $urandom();
         wr(qenc_pkg::REG_STEP_CONST, k);
         run($urandom_range(3, 12), 1'b0);
         rd_chk(qenc_pkg::REG_POSITION, acc[47:16]);
         rd_chk(qenc_pkg::REG_FRACTION, {16'h0000, acc[15:0]});
      end
      enc.pulse(1'b1, 2);
      rd_chk(qenc_pkg::REG_POSITION, acc[47:16]);
      $display("test binary counting done");
      // decimal mode: 51.2, then the largest fraction, then random
      wr(qenc_pkg::REG_CONFIG, 32'h0000_0040);
      wr(qenc_pkg::REG_POSITION, 32'h0000_0000);
      for (int r = 0; r < 4; r++) begin
         k = (r == 0) ? {16'h0033, 16'h07D0} : (r == 1) ? {16'h0000, 16'h270F} :
            {16'($urandom_range(0, 16'h00C8)) - 16'h0064, 16'($urandom_range(0, 16'h270F))};
         wr(qenc_pkg::REG_STEP_CONST, k);
         run($urandom_range(3, 12), 1'b1);
         rd_chk(qenc_pkg::REG_POSITION, acc[47:16]);
         rd_chk(qenc_pkg::REG_FRACTION, {16'h0000, acc[15:0]});
      end
      $display("test decimal counting done");
      // index needs a and b high; first try with b low
      wr(qenc_pkg::REG_CONFIG, 32'h0000_001F);
      for (int i = 0; i < 4 && !(enc_a && enc_b); i++) enc.move(1'b1, 4);
      enc.move(1'b0, 10);
      wr(qenc_pkg::REG_POSITION, 32'h0000_0100);
      enc.pulse(1'b0, 6);
      rd_chk(qenc_pkg::REG_FLAGS, 32'h0);
      rd_chk(qenc_pkg::REG_POSITION, 32'h0000_0100);
      enc.move(1'b1, 10);
      wr(qenc_pkg::REG_CONFIG, 32'h0000_0007);
      wr(qenc_pkg::REG_POSITION, 32'h0000_0100);
      enc.pulse(1'b0, 6);
      rd_chk(qenc_pkg::REG_FLAGS, 32'h0000_0001);
      rd_chk(qenc_pkg::REG_CAPTURED, 32'h0);
      rd_chk(qenc_pkg::REG_POSITION, 32'h0000_0100);
      // continuous: every index clears and captures
      wr(qenc_pkg::REG_FLAGS, 32'h0000_0003);
      wr(qenc_pkg::REG_CONFIG, 32'h0000_001F);
      enc.pulse(1'b0, 6);
      rd_chk(qenc_pkg::REG_POSITION, 32'h0);
      rd_chk(qenc_pkg::REG_CAPTURED, 32'h0000_0100);
      rd_chk(qenc_pkg::REG_FLAGS, 32'h0000_0003);
      wr(qenc_pkg::REG_POSITION, 32'h0000_0200);
      enc.pulse(1'b0, 6);
      rd_chk(qenc_pkg::REG_CAPTURED, 32'h0000_0200);
      rd_chk(qenc_pkg::REG_POSITION, 32'h0);
      // single shot without clear: capture once, then disarm
      wr(qenc_pkg::REG_FLAGS, 32'h0000_0003);
      wr(qenc_pkg::REG_CONFIG, 32'h0000_0027);
      wr(qenc_pkg::REG_POSITION, 32'h0000_0300);
      enc.pulse(1'b0, 6);
      rd_chk(qenc_pkg::REG_POSITION, 32'h0000_0300);
      rd_chk(qenc_pkg::REG_CAPTURED, 32'h0000_0300);
      rd_chk(qenc_pkg::REG_CONFIG, 32'h0000_0007);
      wr(qenc_pkg::REG_POSITION, 32'h0000_0400);
      enc.pulse(1'b0, 6);
      rd_chk(qenc_pkg::REG_CAPTURED, 32'h0000_0300);
      $display("test index handling done");
      // interrupt: flag set but masked, unmasked, then cleared
      irq_chk(1'b0);
      wr(qenc_pkg::REG_IRQ_MASK, 32'h0000_0001);
      irq_chk(1'b1);
      wr(qenc_pkg::REG_FLAGS, 32'h0000_0001);
      irq_chk(1'b0);
      rd_chk(qenc_pkg::REG_FLAGS, 32'h0);
      $display("test interrupt done");
      close_out();
   end
endmodule : tb_quadrature_encoder_counter
